//--- ccs_pkg.sv
// Package of constants and types for the charge cycle sequencer
package ccs_pkg;

    localparam int unsigned CLK_HZ        = 25_000_000;
    // Safety timer tick period in microseconds and cycles per tick
    localparam int unsigned TICK_US       = 1000;
    localparam int unsigned TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
    // Pre-charge timer length in hours and in ticks
    localparam int unsigned PRE_HOURS     = 1;
    localparam int unsigned PRE_TICKS     = PRE_HOURS * 3600 * 1000;
    // Comparator debounce length in cycles
    localparam int unsigned DEB_CYC       = 8;

    // Register offsets
    localparam logic [7:0] FAST_CURRENT_ADDR  = 8'h02;
    localparam logic [7:0] PRE_TERM_ADDR      = 8'h03;
    localparam logic [7:0] FULL_VOLTAGE_ADDR  = 8'h04;
    localparam logic [7:0] THERMAL_ADDR       = 8'h05;
    localparam logic [7:0] FAST_THRESH_ADDR   = 8'h07;
    localparam logic [7:0] CHARGE_CTRL_ADDR   = 8'h08;
    localparam logic [7:0] TIMER_CTRL_ADDR    = 8'h09;
    localparam logic [7:0] OPTION_ADDR        = 8'h30;
    localparam logic [7:0] STATUS_ADDR        = 8'h31;

    // Reset values
    localparam logic [7:0] FAST_CURRENT_RST   = 8'h14;
    localparam logic [7:0] PRE_TERM_RST       = 8'h22;
    localparam logic [7:0] FULL_VOLTAGE_RST   = 8'h40;
    localparam logic [7:0] THERMAL_RST        = 8'h03;
    localparam logic [7:0] FAST_THRESH_RST    = 8'h20;
    localparam logic [7:0] CHARGE_CTRL_RST    = 8'h10;
    localparam logic [7:0] TIMER_CTRL_RST     = 8'h09;
    localparam logic [7:0] OPTION_RST         = 8'h00;

    // Field positions
    localparam int unsigned CHG_EN_BIT        = 4;
    localparam int unsigned SUSPEND_BIT       = 7;
    localparam int unsigned BATT_OFF_BIT      = 6;
    localparam int unsigned TERM_EN_BIT       = 3;
    localparam int unsigned TMR_EN_BIT        = 3;
    localparam int unsigned TMR_DBL_BIT       = 0;
    localparam int unsigned TMR_SEL_LSB       = 1;
    localparam int unsigned PHASE_AUTO_BIT    = 0;
    localparam int unsigned PHASE_MAN_BIT     = 1;

    // Number of comparator flags
    localparam int unsigned NCMP              = 16;

    typedef enum logic [2:0] {
        CCS_IDLE, CCS_TRICKLE, CCS_PRE, CCS_FAST, CCS_CV, CCS_DONE,
        CCS_FAULT
    } ccs_phase_t;

endpackage : ccs_pkg

//--- ccs_debounce.sv
// Synchroniser and debouncer for one comparator flag
`timescale 1ns/1ps
module ccs_debounce
    import ccs_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic raw,
    output logic      clean
);
    logic       s1_ff, s2_ff, clean_ff;
    logic       nxt_clean;
    logic [3:0] cnt_ff, nxt_cnt;

    always_comb begin
        nxt_clean = clean_ff;
        nxt_cnt   = 4'h0;
        if (s2_ff != clean_ff) begin
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == 4'(DEB_CYC - 1)) begin
                nxt_clean = s2_ff;
                nxt_cnt   = 4'h0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff    <= 1'b0;
            s2_ff    <= 1'b0;
            clean_ff <= 1'b0;
            cnt_ff   <= 4'h0;
        end else begin
            s1_ff    <= raw;
            s2_ff    <= s1_ff;
            clean_ff <= nxt_clean;
            cnt_ff   <= nxt_cnt;
        end
    end

    assign clean = clean_ff;
endmodule : ccs_debounce

//--- ccs_adc_mux.sv
// Measurement channel sequencer for the sampling converter
`timescale 1ns/1ps
module ccs_adc_mux
    import ccs_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       otg_mode,
    input  wire logic       sample_done,
    output logic [2:0]      adc_channel
);
    logic [2:0] chan_ff, nxt_chan;
    logic [2:0] last;

    // Charge mode walks five channels, discharge mode four
    always_comb begin
        last     = otg_mode ? 3'h3 : 3'h4;
        nxt_chan = chan_ff;
        if (chan_ff > last)
            nxt_chan = 3'h0;
        else if (sample_done)
            nxt_chan = (chan_ff == last) ? 3'h0 : chan_ff + 3'h1;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            chan_ff <= 3'h0;
        else
            chan_ff <= nxt_chan;
    end

    assign adc_channel = chan_ff;
endmodule : ccs_adc_mux

//--- ccs_sequencer.sv
// Charge cycle sequencer with safety timers and register port
`timescale 1ns/1ps
// Notes on behaviour
// - With input good and battery below trickle threshold, apply trickle current.
// - Pre-charge timer expiring below fast threshold stops cycle, sets timeout.
// - Pre-charge current comes from upper nibble of its setting register.
// - Above the selected fast threshold, enter constant current fast charge.
// - Fast charge current comes from a seven-bit setting field.
// - At full voltage target enter constant voltage charging.
// - With termination on, charge completes when current reaches term level.
// - Complete-charge timer expiring before termination stops, sets timeout.
// - Two-bit field picks thermal threshold; current is cut above it.
// - New cycle needs replug, enable, no thermistor, over-voltage or switch-off.
// - Replug or enable toggle restarts; start phase follows battery voltage.
// - After termination, dropping below recharge threshold restarts and resets timer.
// - Battery over-voltage stops charging and opens the battery switch at once.
// - Virtual diode enters on input good and low system, exits above margin.
// - Suspend bit turns converter off and battery supplies the load.
// - In buck mode below light load one phase may be shed.
// - Converter cycles five charge channels or four discharge channels.
// - One timer covers trickle and pre-charge; fast timer configurable, disable.
// - Safety timer is inactive in discharge mode.
// - Timer restarts on new cycle or rising write of enable bits.
// - Timer pauses during supplement, system over-voltage or thermistor fault.
// - Optionally the timer runs at half rate under limit loops.
module ccs_sequencer
    import ccs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC,
    parameter int unsigned PRE_TIMEOUT = PRE_TICKS,
    parameter int unsigned FAST_UNIT   = 2 * 3600 * 1000
)(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        in_power_good,
    input  wire logic        cmp_batt_trickle,
    input  wire logic        cmp_batt_fast,
    input  wire logic        cmp_batt_full,
    input  wire logic        cmp_batt_recharge,
    input  wire logic        cmp_batt_ov,
    input  wire logic        cmp_term_current,
    input  wire logic        cmp_thermistor_fault,
    input  wire logic        cmp_sys_ov,
    input  wire logic        cmp_supplement,
    input  wire logic        cmp_sys_below_batt,
    input  wire logic        cmp_sys_above_batt,
    input  wire logic        cmp_light_load,
    input  wire logic        cmp_limit_loop,
    input  wire logic        cmp_buck_mode,
    input  wire logic        cmp_otg_mode,
    input  wire logic        cmp_junction_hot,
    input  wire logic        adc_sample_done,
    output logic      [2:0]  adc_channel,
    output logic      [2:0]  charge_phase,
    output logic      [6:0]  charge_current_set,
    output logic      [5:0]  full_voltage_target,
    output logic      [1:0]  fast_charge_threshold,
    output logic      [1:0]  thermal_threshold,
    output logic             thermal_cut,
    output logic             battery_switch_on,
    output logic             virtual_diode,
    output logic             converter_on,
    output logic             phase_shed,
    output logic             timeout_fault
);
    logic [NCMP-1:0] raw_cmp, cmp;

    assign raw_cmp = {cmp_batt_trickle, cmp_batt_fast, cmp_batt_full,
                      cmp_batt_recharge, cmp_batt_ov, cmp_term_current,
                      cmp_thermistor_fault, cmp_sys_ov, cmp_supplement,
                      cmp_sys_below_batt, cmp_sys_above_batt, cmp_light_load,
                      cmp_limit_loop, cmp_buck_mode, cmp_otg_mode,
                      cmp_junction_hot};

    // Every comparator flag passes a synchroniser and debouncer; in_power_good is used undebounced
    for (genvar i = 0; i < NCMP; i++) begin : g_deb
        ccs_debounce u_deb (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .raw      (raw_cmp[i]),
            .clean    (cmp[i])
        );
    end

    logic above_trickle, above_fast, at_full, below_recharge, batt_ov;
    logic term_reached, therm_fault, sys_ov, supplement, sys_low, sys_high;
    logic light_load, limit_loop, buck_mode, otg_mode, junction_hot;
    assign {above_trickle, above_fast, at_full, below_recharge, batt_ov,
            term_reached, therm_fault, sys_ov, supplement, sys_low, sys_high,
            light_load, limit_loop, buck_mode, otg_mode, junction_hot} = cmp;

    ccs_adc_mux u_adc (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .otg_mode    (otg_mode),
        .sample_done (adc_sample_done),
        .adc_channel (adc_channel)
    );

    // Register file
    logic [7:0] fast_cur_ff, pre_term_ff, full_v_ff, thermal_ff;
    logic [7:0] fast_th_ff, chg_ctrl_ff, tmr_ctrl_ff, option_ff;
    logic [7:0] nxt_fast_cur, nxt_pre_term, nxt_full_v, nxt_thermal;
    logic [7:0] nxt_fast_th, nxt_chg_ctrl, nxt_tmr_ctrl, nxt_option;
    logic [7:0] rdata_ff, nxt_rdata;
    logic       chg_en_rise, tmr_en_rise;
    logic       timeout_ff, nxt_timeout;
    ccs_phase_t phase_ff, nxt_phase;

    always_comb begin
        nxt_fast_cur = fast_cur_ff;
        nxt_pre_term = pre_term_ff;
        nxt_full_v   = full_v_ff;
        nxt_thermal  = thermal_ff;
        nxt_fast_th  = fast_th_ff;
        nxt_chg_ctrl = chg_ctrl_ff;
        nxt_tmr_ctrl = tmr_ctrl_ff;
        nxt_option   = option_ff;
        nxt_rdata    = 8'h00;
        if (reg_wr) begin
            unique case (reg_addr)
                FAST_CURRENT_ADDR: nxt_fast_cur = reg_wdata;
                PRE_TERM_ADDR:     nxt_pre_term = reg_wdata;
                FULL_VOLTAGE_ADDR: nxt_full_v   = reg_wdata;
                THERMAL_ADDR:      nxt_thermal  = reg_wdata;
                FAST_THRESH_ADDR:  nxt_fast_th  = reg_wdata;
                CHARGE_CTRL_ADDR:  nxt_chg_ctrl = reg_wdata;
                TIMER_CTRL_ADDR:   nxt_tmr_ctrl = reg_wdata;
                OPTION_ADDR:       nxt_option   = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                FAST_CURRENT_ADDR: nxt_rdata = fast_cur_ff;
                PRE_TERM_ADDR:     nxt_rdata = pre_term_ff;
                FULL_VOLTAGE_ADDR: nxt_rdata = full_v_ff;
                THERMAL_ADDR:      nxt_rdata = thermal_ff;
                FAST_THRESH_ADDR:  nxt_rdata = fast_th_ff;
                CHARGE_CTRL_ADDR:  nxt_rdata = chg_ctrl_ff;
                TIMER_CTRL_ADDR:   nxt_rdata = tmr_ctrl_ff;
                OPTION_ADDR:       nxt_rdata = option_ff;
                STATUS_ADDR:       nxt_rdata = {timeout_ff, 4'h0,
                                                3'(phase_ff)};
                default:           nxt_rdata = 8'h00;
            endcase
        end
    end

    // Rising writes of the enable bits restart the timer
    assign chg_en_rise = nxt_chg_ctrl[CHG_EN_BIT]
                         & ~chg_ctrl_ff[CHG_EN_BIT];
    assign tmr_en_rise = nxt_tmr_ctrl[TMR_EN_BIT]
                         & ~tmr_ctrl_ff[TMR_EN_BIT];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_cur_ff <= FAST_CURRENT_RST;
            pre_term_ff <= PRE_TERM_RST;
            full_v_ff   <= FULL_VOLTAGE_RST;
            thermal_ff  <= THERMAL_RST;
            fast_th_ff  <= FAST_THRESH_RST;
            chg_ctrl_ff <= CHARGE_CTRL_RST;
            tmr_ctrl_ff <= TIMER_CTRL_RST;
            option_ff   <= OPTION_RST;
            rdata_ff    <= 8'h00;
        end else begin
            fast_cur_ff <= nxt_fast_cur;
            pre_term_ff <= nxt_pre_term;
            full_v_ff   <= nxt_full_v;
            thermal_ff  <= nxt_thermal;
            fast_th_ff  <= nxt_fast_th;
            chg_ctrl_ff <= nxt_chg_ctrl;
            tmr_ctrl_ff <= nxt_tmr_ctrl;
            option_ff   <= nxt_option;
            rdata_ff    <= nxt_rdata;
        end
    end

    logic chg_en, suspend, batt_off, term_en, tmr_en, dbl_en;
    assign chg_en   = chg_ctrl_ff[CHG_EN_BIT];
    assign suspend  = chg_ctrl_ff[SUSPEND_BIT];
    assign batt_off = chg_ctrl_ff[BATT_OFF_BIT];
    assign term_en  = chg_ctrl_ff[TERM_EN_BIT];
    assign tmr_en   = tmr_ctrl_ff[TMR_EN_BIT];
    assign dbl_en   = tmr_ctrl_ff[TMR_DBL_BIT];

    // Tick prescaler, half rate while doubling is in force
    logic [31:0] pre_cnt_ff, nxt_pre_cnt;
    logic        half_ff, nxt_half, tick;
    logic        slow;

    assign slow = dbl_en & (limit_loop | junction_hot);

    always_comb begin
        tick        = 1'b0;
        nxt_half    = half_ff;
        nxt_pre_cnt = pre_cnt_ff + 32'h1;
        if (pre_cnt_ff >= 32'(TICK_CYCLES - 1)) begin
            nxt_pre_cnt = 32'h0;
            nxt_half    = ~half_ff;
            tick        = ~slow | half_ff;
        end
    end

    // Charge phase machine and safety timer
    logic        pg_ff, chg_en_d_ff, nxt_pg, nxt_chg_en_d;
    logic [31:0] tmr_ff, nxt_tmr;
    logic        start, inhibit, restart, paused;
    logic [31:0] fast_limit, limit;
    ccs_phase_t  entry_phase;

    assign inhibit = ~chg_en | therm_fault | batt_ov | batt_off;
    assign restart = (in_power_good & ~pg_ff)
                     | (chg_en & ~chg_en_d_ff);
    assign start   = restart & in_power_good & ~inhibit;
    assign paused  = supplement | sys_ov | therm_fault;
    assign fast_limit = 32'(FAST_UNIT) *
                        32'(tmr_ctrl_ff[TMR_SEL_LSB +: 2] + 3'h1);
    assign limit   = above_fast ? fast_limit : 32'(PRE_TIMEOUT);

    always_comb begin
        if (!above_trickle)
            entry_phase = CCS_TRICKLE;
        else if (!above_fast)
            entry_phase = CCS_PRE;
        else if (!at_full)
            entry_phase = CCS_FAST;
        else
            entry_phase = CCS_CV;
    end

    always_comb begin
        nxt_phase    = phase_ff;
        nxt_timeout  = timeout_ff;
        nxt_pg       = in_power_good;
        nxt_chg_en_d = chg_en;
        nxt_tmr      = tmr_ff;
        if (tick && tmr_en && !paused && !otg_mode)
            nxt_tmr = tmr_ff + 32'h1;
        unique case (phase_ff)
            CCS_IDLE, CCS_FAULT: begin
                if (start) begin
                    nxt_phase   = entry_phase;
                    nxt_timeout = 1'b0;
                end
            end
            CCS_TRICKLE: if (above_trickle) nxt_phase = CCS_PRE;
            CCS_PRE:     if (above_fast)    nxt_phase = CCS_FAST;
            CCS_FAST:    if (at_full)       nxt_phase = CCS_CV;
            CCS_CV: if (term_en && term_reached)
                         nxt_phase = CCS_DONE;
            CCS_DONE: begin
                if (below_recharge && in_power_good && !inhibit) begin
                    nxt_phase = entry_phase;
                    nxt_tmr   = 32'h0;
                end
            end
        endcase
        if (phase_ff inside {CCS_TRICKLE, CCS_PRE, CCS_FAST, CCS_CV}) begin
            // A timeout that meets a stop still ends in the fault phase
            if (inhibit || !in_power_good)
                nxt_phase = CCS_IDLE;
            if (tmr_en && tmr_ff >= limit) begin
                nxt_phase   = CCS_FAULT;
                nxt_timeout = 1'b1;
            end
        end
        if (start || chg_en_rise || tmr_en_rise)
            nxt_tmr = 32'h0;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff    <= CCS_IDLE;
            timeout_ff  <= 1'b0;
            pg_ff       <= 1'b0;
            chg_en_d_ff <= CHARGE_CTRL_RST[CHG_EN_BIT];
            tmr_ff      <= 32'h0;
            pre_cnt_ff  <= 32'h0;
            half_ff     <= 1'b0;
        end else begin
            phase_ff    <= nxt_phase;
            timeout_ff  <= nxt_timeout;
            pg_ff       <= nxt_pg;
            chg_en_d_ff <= nxt_chg_en_d;
            tmr_ff      <= nxt_tmr;
            pre_cnt_ff  <= nxt_pre_cnt;
            half_ff     <= nxt_half;
        end
    end

    // Power path decisions
    logic vd_ff, nxt_vd, out_ff, nxt_out;
    logic [15:0] set_ff, nxt_set;

    always_comb begin
        nxt_vd = vd_ff;
        if (in_power_good && sys_low)
            nxt_vd = 1'b1;
        else if (sys_high)
            nxt_vd = 1'b0;
        nxt_out = ~suspend & in_power_good;
        nxt_set = {3'h0, otg_mode, 2'h0, 1'b0,
                   ~(batt_ov | batt_off), 1'b0, fast_cur_ff[6:0]};
        unique case (phase_ff)
            CCS_TRICKLE, CCS_PRE:
                nxt_set[6:0] = {3'h0, pre_term_ff[7:4]};
            CCS_FAST, CCS_CV:
                nxt_set[6:0] = fast_cur_ff[6:0];
            default:
                nxt_set[6:0] = 7'h00;
        endcase
        nxt_set[12] = buck_mode & light_load
                      & (option_ff[PHASE_MAN_BIT]
                         | option_ff[PHASE_AUTO_BIT]);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vd_ff  <= 1'b0;
            out_ff <= 1'b0;
            set_ff <= 16'h0000;
        end else begin
            vd_ff  <= nxt_vd;
            out_ff <= nxt_out;
            set_ff <= nxt_set;
        end
    end

    assign reg_rdata             = rdata_ff;
    assign charge_phase          = 3'(phase_ff);
    assign charge_current_set    = set_ff[6:0];
    assign full_voltage_target   = full_v_ff[6:1];
    assign fast_charge_threshold = fast_th_ff[5:4];
    assign thermal_threshold     = thermal_ff[1:0];
    assign thermal_cut           = junction_hot;
    assign battery_switch_on     = set_ff[8];
    assign virtual_diode         = vd_ff;
    assign converter_on          = out_ff;
    assign phase_shed            = set_ff[12];
    assign timeout_fault         = timeout_ff;
endmodule : ccs_sequencer

//--- ccs_sequencer_chk.sv
// Port-level property checker for the charge cycle sequencer
`timescale 1ns/1ps
module ccs_sequencer_chk
    import ccs_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       cmp_batt_ov,
    input wire logic       cmp_sys_above_batt,
    input wire logic       cmp_junction_hot,
    input wire logic       cmp_otg_mode,
    input wire logic [2:0] adc_channel,
    input wire logic [2:0] charge_phase,
    input wire logic [6:0] charge_current_set,
    input wire logic       thermal_cut,
    input wire logic       battery_switch_on,
    input wire logic       virtual_diode,
    input wire logic       timeout_fault
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside read slot");
    property p_hot_cut;
        cmp_junction_hot[*8] ##1 cmp_junction_hot[*8] |-> thermal_cut;
    endproperty
    a_hot_cut: assert property (p_hot_cut)
        else $error("thermal cut missing");
    property p_ov_stop;
        cmp_batt_ov[*8] ##1 cmp_batt_ov[*8] |-> !battery_switch_on &&
            !(charge_phase inside {[3'h1:3'h4]});
    endproperty
    a_ov_stop: assert property (p_ov_stop)
        else $error("charging continues in over-voltage");
    property p_vd_exit;
        cmp_sys_above_batt[*8] ##1 cmp_sys_above_batt[*8] |-> !virtual_diode;
    endproperty
    a_vd_exit: assert property (p_vd_exit)
        else $error("virtual diode did not exit");
    property p_tmo_fault;
        $rose(timeout_fault) |-> charge_phase == 3'h6;
    endproperty
    a_tmo_fault: assert property (p_tmo_fault)
        else $error("timeout without fault phase");
    property p_pre_cur;
        charge_phase inside {3'h1, 3'h2} |-> charge_current_set[6:4] == 3'h0;
    endproperty
    a_pre_cur: assert property (p_pre_cur)
        else $error("pre-charge current wider than nibble");
    property p_done_from_cv;
        $changed(charge_phase) && charge_phase == 3'h5
            |-> $past(charge_phase) == 3'h4;
    endproperty
    a_done_from_cv: assert property (p_done_from_cv)
        else $error("charge complete not from constant voltage");
    property p_adc_seq;
        adc_channel <= 3'h4 && (!$changed(adc_channel) ||
            adc_channel == 3'h0 || adc_channel == $past(adc_channel) + 3'h1);
    endproperty
    a_adc_seq: assert property (p_adc_seq)
        else $error("measurement channel out of sequence");
    property p_otg_chan;
        cmp_otg_mode[*8] ##1 cmp_otg_mode[*8] |-> adc_channel <= 3'h3;
    endproperty
    a_otg_chan: assert property (p_otg_chan)
        else $error("discharge mode uses a charge-only channel");
    c_done: cover property (charge_phase == 3'h5);
    c_tmo: cover property ($rose(timeout_fault));
    c_vd: cover property ($rose(virtual_diode));
endmodule : ccs_sequencer_chk

//--- ccs_host.sv
// Host model that drives the register port
`timescale 1ns/1ps
module ccs_host (
    input  wire logic       core_clk,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~v;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
endmodule : ccs_host

//--- charge_cycle_sequencer_tb.sv
// Self-checking bench for the charge cycle sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    n_errors++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module charge_cycle_sequencer_tb
    import ccs_pkg::*;
;
    logic core_clk, rst_n, reg_wr, reg_rd, adc_sample_done;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, fc;
    logic in_power_good, cmp_batt_trickle, cmp_batt_fast, cmp_batt_full,
        cmp_batt_recharge, cmp_batt_ov, cmp_term_current, cmp_sys_ov,
        cmp_thermistor_fault, cmp_supplement, cmp_sys_below_batt,
        cmp_sys_above_batt, cmp_light_load, cmp_limit_loop, cmp_buck_mode,
        cmp_otg_mode, cmp_junction_hot;
    logic [2:0] adc_channel, charge_phase;
    logic [6:0] charge_current_set;
    logic [5:0] full_voltage_target;
    logic [1:0] fast_charge_threshold, thermal_threshold;
    logic thermal_cut, battery_switch_on, virtual_diode, converter_on,
        phase_shed, timeout_fault;
    int n_errors, samples_checked, cyc, i;
    integer seed = 32'h0e2f;
    logic [7:0] ra [9] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08,
        8'h09, 8'h30, 8'h06};
    logic [7:0] rv [9] = '{FAST_CURRENT_RST, PRE_TERM_RST, FULL_VOLTAGE_RST,
        THERMAL_RST, FAST_THRESH_RST, CHARGE_CTRL_RST, TIMER_CTRL_RST,
        OPTION_RST, 8'h00};
    ccs_sequencer #(.TICK_CYCLES(2), .PRE_TIMEOUT(20), .FAST_UNIT(30))
        u_dut (.*);
    ccs_host u_host (.*);
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        adc_sample_done <= ($random(seed) & 3) == 0;
        if (cyc == 5000) begin
            n_errors++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done
    // Waits a bounded time for a phase, then compares it
    task automatic wph(input logic [2:0] p);
        for (int k = 0; k < 300 && charge_phase !== p; k++)
            @(negedge core_clk);
        `CHK(charge_phase, p)
        @(negedge core_clk);
    endtask : wph
    task automatic gap();
        repeat (16) @(negedge core_clk);
    endtask : gap
    initial begin
        rst_n = 1'b0;
        {in_power_good, cmp_batt_trickle, cmp_batt_fast, cmp_batt_full,
            cmp_batt_recharge, cmp_batt_ov, cmp_term_current, cmp_sys_ov,
            cmp_thermistor_fault, cmp_supplement, cmp_sys_below_batt,
            cmp_sys_above_batt, cmp_light_load, cmp_limit_loop,
            cmp_buck_mode, cmp_otg_mode, cmp_junction_hot} = '0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 9; i++) begin
            u_host.rd(ra[i], d);
            `CHK(d, rv[i])
        end
        `CHK(full_voltage_target, FULL_VOLTAGE_RST[6:1])
        fc = $random(seed);
        u_host.wr(FULL_VOLTAGE_ADDR, fc);
        u_host.wr(THERMAL_ADDR, fc);
        u_host.wr(FAST_THRESH_ADDR, fc);
        u_host.wr(PRE_TERM_ADDR, fc);
        @(negedge core_clk);
        `CHK(full_voltage_target, fc[6:1])
        `CHK(thermal_threshold, fc[1:0])
        `CHK(fast_charge_threshold, fc[5:4])
        @(posedge core_clk) cmp_junction_hot <= 1'b1;
        gap();
        `CHK(thermal_cut, 1'b1)
        @(posedge core_clk) cmp_junction_hot <= 1'b0;
        $display("end of test registers");
        @(posedge core_clk) in_power_good <= 1'b1;
        wph(3'h1);
        `CHK(charge_current_set, {3'h0, fc[7:4]})
        @(posedge core_clk) cmp_batt_trickle <= 1'b1;
        wph(3'h2);
        wph(3'h6);
        `CHK(timeout_fault, 1'b1)
        u_host.wr(STATUS_ADDR, 8'hFF);
        u_host.rd(STATUS_ADDR, d);
        `CHK(d, 8'h86)
        $display("end of test pre-charge timeout");
        fc = $random(seed);
        @(posedge core_clk) cmp_batt_fast <= 1'b1;
        u_host.wr(TIMER_CTRL_ADDR, 8'h0E);
        u_host.wr(FAST_CURRENT_ADDR, fc);
        gap();
        u_host.wr(CHARGE_CTRL_ADDR, 8'h00);
        u_host.wr(CHARGE_CTRL_ADDR, 8'h18);
        wph(3'h3);
        `CHK(charge_current_set, fc[6:0])
        @(posedge core_clk) cmp_batt_full <= 1'b1;
        wph(3'h4);
        @(posedge core_clk) cmp_term_current <= 1'b1;
        wph(3'h5);
        @(posedge core_clk) cmp_batt_recharge <= 1'b1;
        cmp_term_current <= 1'b0;
        cmp_batt_full <= 1'b0;
        wph(3'h3);
        @(posedge core_clk) cmp_batt_recharge <= 1'b0;
        u_host.wr(OPTION_ADDR, 8'h02);
        cmp_buck_mode <= 1'b1;
        cmp_light_load <= 1'b1;
        gap();
        `CHK(phase_shed, 1'b1)
        @(posedge core_clk) cmp_light_load <= 1'b0;
        gap();
        `CHK(phase_shed, 1'b0)
        u_host.wr(TIMER_CTRL_ADDR, 8'h06);
        u_host.wr(TIMER_CTRL_ADDR, 8'h08);
        wph(3'h6);
        $display("end of test full cycle");
        u_host.wr(CHARGE_CTRL_ADDR, 8'h00);
        u_host.wr(CHARGE_CTRL_ADDR, 8'h18);
        wph(3'h3);
        @(posedge core_clk) cmp_batt_ov <= 1'b1;
        wph(3'h0);
        `CHK(battery_switch_on, 1'b0)
        u_host.wr(CHARGE_CTRL_ADDR, 8'h00);
        u_host.wr(CHARGE_CTRL_ADDR, 8'h18);
        gap();
        `CHK(charge_phase, 3'h0)
        @(posedge core_clk) cmp_batt_ov <= 1'b0;
        cmp_otg_mode <= 1'b1;
        cmp_sys_below_batt <= 1'b1;
        gap();
        `CHK(virtual_diode, 1'b1)
        @(posedge core_clk) cmp_sys_below_batt <= 1'b0;
        cmp_sys_above_batt <= 1'b1;
        gap();
        `CHK(virtual_diode, 1'b0)
        `CHK(converter_on, 1'b1)
        u_host.wr(CHARGE_CTRL_ADDR, 8'h98);
        repeat (4) @(negedge core_clk);
        `CHK(converter_on, 1'b0)
        $display("end of test protection");
        test_done();
    end
endmodule : charge_cycle_sequencer_tb
bind ccs_sequencer ccs_sequencer_chk u_chk (.*);
